// file: lcdpp_defs.svh
`ifndef LCDPP_DEFS_SVH
`define LCDPP_DEFS_SVH

// register offsets on the plain register port
`define LCDPP_ADDR_W          9
`define LCDPP_ADDR_CTRL       9'h107
`define LCDPP_ADDR_PHASE      9'h108

// display_control field positions and reset value
`define LCDPP_CTRL_ON_BIT     7
`define LCDPP_CTRL_MUX_HI     1
`define LCDPP_CTRL_MUX_LO     0
`define LCDPP_CTRL_ON_RST     1'h0
`define LCDPP_CTRL_MUX_RST    2'h3

// display_phase_prescale field positions and reset values
`define LCDPP_PS_WFT_BIT      7
`define LCDPP_PS_BIAS_BIT     6
`define LCDPP_PS_ACT_BIT      5
`define LCDPP_PS_PERMIT_BIT   4
`define LCDPP_PS_RATIO_HI     3
`define LCDPP_PS_RATIO_LO     0
`define LCDPP_PS_WFT_RST      1'h0
`define LCDPP_PS_BIAS_RST     1'h0
`define LCDPP_PS_RATIO_RST    4'h0

// multiplex selections
`define LCDPP_MUX_STATIC      2'h0
`define LCDPP_MUX_TWO         2'h1
`define LCDPP_MUX_FOUR        2'h3

`endif

// file: lcdpp_pkg.sv
package lcdpp_pkg;

    // drive bias level presented to the analog drivers
    typedef enum logic [1:0]
    {
        LCDPP_BIAS_STATIC,
        LCDPP_BIAS_HALF,
        LCDPP_BIAS_THIRD
    } lcdpp_bias_e;

    typedef logic [7:0] lcdpp_data_t;

endpackage : lcdpp_pkg

// file: lcdpp_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "lcdpp_defs.svh"
// Function
// (R01) type B: phase flips only per frame
// (R02) type A: phase flips inside each common
// (R03) software keeps bias zero when static
// (R04) two commons: bias bit picks half/third
// (R05) read-only active flag shows driver running
// (R06) read-only permit flag allows pixel writes
// (R07) prescale divide ratio is field plus one
// (R08) driver_on starts/stops driver, flag follows
// (R09) one tick per ratio source ticks, restarts
module lcdpp_top
    import lcdpp_pkg::*;
#(
    parameter int RATIO_W = 4
)
(
    input  wire logic                      core_clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic [`LCDPP_ADDR_W-1:0]  reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic [7:0]                     reg_rdata_out,
    input  wire logic                      src_tick_in,
    output logic                           presc_tick_out,
    output logic [1:0]                     com_index_out,
    output logic                           drive_phase_out,
    output logic                           frame_start_out,
    output lcdpp_bias_e                    bias_mode_out
);

    // software-visible configuration
    logic               driver_on_r,          driver_on_nxt;
    logic [1:0]         common_count_sel_r,   common_count_sel_nxt;
    logic               waveform_type_sel_r,  waveform_type_sel_nxt;
    logic               bias_select_r,        bias_select_nxt;
    logic [RATIO_W-1:0] prescale_ratio_r,     prescale_ratio_nxt;
    lcdpp_data_t        rdata_r,              rdata_nxt;

    // driver state
    logic               driver_active_flag_r, driver_active_flag_nxt;
    logic               pixel_write_permit_r, pixel_write_permit_nxt;
    logic [RATIO_W-1:0] div_cnt_r,            div_cnt_nxt;
    logic               presc_tick_r,         presc_tick_nxt;
    logic [1:0]         com_r,                com_nxt;
    logic               phase_r,              phase_nxt;
    logic               frame_start_r,        frame_start_nxt;
    lcdpp_bias_e        bias_mode_r,          bias_mode_nxt;

    logic               wr_ctrl;
    logic               wr_phase;
    logic               advance_com;
    logic               last_com;

    assign wr_ctrl  = reg_wr_in && (reg_addr_in == `LCDPP_ADDR_CTRL);
    assign wr_phase = reg_wr_in && (reg_addr_in == `LCDPP_ADDR_PHASE);

    // register writes and read data; status bits are read-only and ignore writes
    always_comb
    begin
        driver_on_nxt         = driver_on_r;
        common_count_sel_nxt  = common_count_sel_r;
        waveform_type_sel_nxt = waveform_type_sel_r;
        bias_select_nxt       = bias_select_r;
        prescale_ratio_nxt    = prescale_ratio_r;
        rdata_nxt             = 8'h00;
        if (wr_ctrl)
        begin
            driver_on_nxt        = reg_wdata_in[`LCDPP_CTRL_ON_BIT];  // R08
            common_count_sel_nxt = reg_wdata_in[`LCDPP_CTRL_MUX_HI:`LCDPP_CTRL_MUX_LO];
        end
        if (wr_phase)
        begin
            waveform_type_sel_nxt = reg_wdata_in[`LCDPP_PS_WFT_BIT];
            bias_select_nxt       = reg_wdata_in[`LCDPP_PS_BIAS_BIT];
            prescale_ratio_nxt    = reg_wdata_in[`LCDPP_PS_RATIO_HI:`LCDPP_PS_RATIO_LO];
        end
        if (reg_rd_in && (reg_addr_in == `LCDPP_ADDR_CTRL))
        begin
            rdata_nxt[`LCDPP_CTRL_ON_BIT]                       = driver_on_r;
            rdata_nxt[`LCDPP_CTRL_MUX_HI:`LCDPP_CTRL_MUX_LO]    = common_count_sel_r;
        end
        else if (reg_rd_in && (reg_addr_in == `LCDPP_ADDR_PHASE))
        begin
            rdata_nxt[`LCDPP_PS_WFT_BIT]                        = waveform_type_sel_r;
            rdata_nxt[`LCDPP_PS_BIAS_BIT]                       = bias_select_r;
            rdata_nxt[`LCDPP_PS_ACT_BIT]                        = driver_active_flag_r; // R05
            rdata_nxt[`LCDPP_PS_PERMIT_BIT]                     = pixel_write_permit_r; // R06
            rdata_nxt[`LCDPP_PS_RATIO_HI:`LCDPP_PS_RATIO_LO]    = prescale_ratio_r;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            driver_on_r         <= `LCDPP_CTRL_ON_RST;
            common_count_sel_r  <= `LCDPP_CTRL_MUX_RST;
            waveform_type_sel_r <= `LCDPP_PS_WFT_RST;
            bias_select_r       <= `LCDPP_PS_BIAS_RST;
            prescale_ratio_r    <= `LCDPP_PS_RATIO_RST;
            rdata_r             <= 8'h00;
        end
        else
        begin
            driver_on_r         <= driver_on_nxt;
            common_count_sel_r  <= common_count_sel_nxt;
            waveform_type_sel_r <= waveform_type_sel_nxt;
            bias_select_r       <= bias_select_nxt;
            prescale_ratio_r    <= prescale_ratio_nxt;
            rdata_r             <= rdata_nxt;
        end
    end

    assign last_com    = (com_r == common_count_sel_r);
    // type A advances the common after the second half-slot, type B on every tick
    assign advance_com = presc_tick_r && (waveform_type_sel_r || phase_r); // R01 R02

    // prescaler, common sequencer and status; divider, common and phase restart while inactive
    always_comb
    begin
        driver_active_flag_nxt = driver_on_r;                               // R08
        div_cnt_nxt            = div_cnt_r;
        presc_tick_nxt         = 1'b0;
        com_nxt                = com_r;
        phase_nxt              = phase_r;
        frame_start_nxt        = 1'b0;
        if (!driver_active_flag_r)
        begin
            div_cnt_nxt = '0;                                               // R09
            com_nxt     = 2'h0;
            phase_nxt   = 1'b0;
        end
        else
        begin
            if (src_tick_in)
            begin
                if (div_cnt_r >= prescale_ratio_r)                          // R07
                begin
                    div_cnt_nxt    = '0;
                    presc_tick_nxt = 1'b1;                                  // R09
                end
                else
                begin
                    div_cnt_nxt = div_cnt_r + 1'b1;
                end
            end
            if (presc_tick_r && !waveform_type_sel_r)
            begin
                phase_nxt = !phase_r;                                       // R02
            end
            if (advance_com)
            begin
                if (last_com || (com_r > common_count_sel_r))
                begin
                    com_nxt         = 2'h0;
                    frame_start_nxt = 1'b1;
                    if (waveform_type_sel_r)
                    begin
                        phase_nxt = !phase_r;                               // R01
                    end
                end
                else
                begin
                    com_nxt = com_r + 2'h1;
                end
            end
        end
        // pixel writes are held off during the last common so an update lands on a frame edge
        pixel_write_permit_nxt = !driver_active_flag_nxt
                                 || (com_nxt != common_count_sel_r);         // R06
        // static drive forces static bias; four commons only supports one-third
        if (common_count_sel_r == `LCDPP_MUX_STATIC)
        begin
            bias_mode_nxt = LCDPP_BIAS_STATIC;                              // R03
        end
        else if (bias_select_r && (common_count_sel_r != `LCDPP_MUX_FOUR))
        begin
            bias_mode_nxt = LCDPP_BIAS_HALF;                                // R04
        end
        else
        begin
            bias_mode_nxt = LCDPP_BIAS_THIRD;                               // R04
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            driver_active_flag_r <= 1'b0;
            pixel_write_permit_r <= 1'b1;
            div_cnt_r            <= '0;
            presc_tick_r         <= 1'b0;
            com_r                <= 2'h0;
            phase_r              <= 1'b0;
            frame_start_r        <= 1'b0;
            bias_mode_r          <= LCDPP_BIAS_THIRD;
        end
        else
        begin
            driver_active_flag_r <= driver_active_flag_nxt;
            pixel_write_permit_r <= pixel_write_permit_nxt;
            div_cnt_r            <= div_cnt_nxt;
            presc_tick_r         <= presc_tick_nxt;
            com_r                <= com_nxt;
            phase_r              <= phase_nxt;
            frame_start_r        <= frame_start_nxt;
            bias_mode_r          <= bias_mode_nxt;
        end
    end

    assign reg_rdata_out   = rdata_r;
    assign presc_tick_out  = presc_tick_r;
    assign com_index_out   = com_r;
    assign drive_phase_out = phase_r;
    assign frame_start_out = frame_start_r;
    assign bias_mode_out   = bias_mode_r;

    // helper: source ticks since the last output tick, valid only after a clean period
    logic [RATIO_W:0] seen_r,  seen_nxt;
    logic             clean_r, clean_nxt;

    // a ratio write spoils the running period, so the next one is not checked
    always_comb
    begin
        seen_nxt  = '0;
        clean_nxt = 1'b0;
        if (driver_active_flag_r)
        begin
            seen_nxt  = presc_tick_r ? {{RATIO_W{1'b0}}, src_tick_in}
                                     : seen_r + {{RATIO_W{1'b0}}, src_tick_in};
            clean_nxt = !wr_phase && (clean_r || presc_tick_r);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            seen_r  <= '0;
            clean_r <= 1'b0;
        end
        else
        begin
            seen_r  <= seen_nxt;
            clean_r <= clean_nxt;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_type_b_frame: assert property (                                       // R01
        (waveform_type_sel_r && $past(waveform_type_sel_r) && driver_active_flag_r
         && $past(driver_active_flag_r) && $changed(phase_r)) |-> frame_start_r)
        else $error("type B phase changed away from a frame boundary");
    a_type_a_toggle: assert property (                                      // R02
        (presc_tick_r && !waveform_type_sel_r && driver_active_flag_r && driver_on_r)
        |=> (phase_r != $past(phase_r)))
        else $error("type A phase did not flip on a prescaled tick");
    a_bias_two_com: assert property (                                       // R04
        (common_count_sel_r == `LCDPP_MUX_TWO && $stable(common_count_sel_r))
        |=> (bias_mode_r == ($past(bias_select_r) ? LCDPP_BIAS_HALF : LCDPP_BIAS_THIRD)))
        else $error("two-common bias does not match bias select");
    a_active_read: assert property (                                        // R05
        (reg_rd_in && reg_addr_in == `LCDPP_ADDR_PHASE)
        |=> (reg_rdata_out[`LCDPP_PS_ACT_BIT] == $past(driver_active_flag_r)))
        else $error("active flag read back wrong");
    a_permit_idle: assert property (                                        // R06
        (!driver_on_r ##1 !driver_on_r) |=> pixel_write_permit_r)
        else $error("pixel writes blocked while driver idle");
    a_ratio_period: assert property (                                       // R07
        (presc_tick_out && clean_r && $stable(prescale_ratio_r))
        |-> (seen_r == {1'b0, $past(prescale_ratio_r)} + 1'b1))
        else $error("prescaler period differs from ratio plus one");
    a_enable_follow: assert property (                                      // R08
        $rose(driver_on_r) |-> ##1 driver_active_flag_r [*2])
        else $error("active flag did not follow driver enable");
    a_restart_idle: assert property (                                       // R09
        !driver_active_flag_r |=> (!presc_tick_out && com_index_out == 2'h0))
        else $error("prescaler or sequencer ran while inactive");

    c_type_a_frame: cover property (frame_start_out && !waveform_type_sel_r);
    c_type_b_frame: cover property (frame_start_out && waveform_type_sel_r);
    c_write_held:   cover property (driver_active_flag_r && !pixel_write_permit_r);
    c_ratio_max:    cover property (presc_tick_out && prescale_ratio_r == 4'hF);

endmodule : lcdpp_top

// file: lcdpp_top_tb_top.sv
`timescale 1ns/1ps
`include "lcdpp_defs.svh"
module lcdpp_top_tb_top
    import lcdpp_pkg::*;
;
    typedef struct
    {
        logic [7:0]  ctrl;
        logic [7:0]  ps;
        logic [7:0]  exp_ps;
        lcdpp_bias_e exp_bias;
    } lcdpp_row_s;

    logic                     core_clk_in;
    logic                     reset_n_in;
    logic [`LCDPP_ADDR_W-1:0] reg_addr_in;
    logic [7:0]               reg_wdata_in;
    logic                     reg_wr_in;
    logic                     reg_rd_in;
    logic [7:0]               reg_rdata_out;
    logic                     src_tick_in;
    logic                     presc_tick_out;
    logic [1:0]               com_index_out;
    logic                     drive_phase_out;
    logic                     frame_start_out;
    lcdpp_bias_e              bias_mode_out;
    int                       n_mismatch = 0;
    int                       tests_run  = 0;
    int                       cyc        = 0;
    int                       n_presc    = 0;
    int                       n_frame    = 0;
    int                       n_tog      = 0;
    int                       base_p;
    int                       base_f;
    int                       base_t;
    logic                     ph_q       = 1'b0;
    logic [7:0]               rdv;
    // driver is off in every row, so status reads active 0, permit 1
    lcdpp_row_s rows [7] = '{
        '{8'h00, 8'h00, 8'h10, LCDPP_BIAS_STATIC},
        '{8'h01, 8'h40, 8'h50, LCDPP_BIAS_HALF},
        '{8'h01, 8'h83, 8'h93, LCDPP_BIAS_THIRD},
        '{8'h02, 8'hC0, 8'hD0, LCDPP_BIAS_HALF},
        '{8'h7F, 8'h40, 8'h50, LCDPP_BIAS_THIRD},
        '{8'h01, 8'hFF, 8'hDF, LCDPP_BIAS_HALF},
        '{8'h03, 8'h30, 8'h10, LCDPP_BIAS_THIRD}};
    int ratios [3] = '{0, 3, 15};

    lcdpp_top lcdpp_top_i (
        .core_clk_in     (core_clk_in),
        .reset_n_in      (reset_n_in),
        .reg_addr_in     (reg_addr_in),
        .reg_wdata_in    (reg_wdata_in),
        .reg_wr_in       (reg_wr_in),
        .reg_rd_in       (reg_rd_in),
        .reg_rdata_out   (reg_rdata_out),
        .src_tick_in     (src_tick_in),
        .presc_tick_out  (presc_tick_out),
        .com_index_out   (com_index_out),
        .drive_phase_out (drive_phase_out),
        .frame_start_out (frame_start_out),
        .bias_mode_out   (bias_mode_out)
    );

    // 20 MHz clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    // free-running event counters; tests compare deltas, not absolutes
    // sampled mid-cycle so a check at the next rising edge never races the count
    always @(negedge core_clk_in)
    begin
        cyc = cyc + 1;
        if (presc_tick_out === 1'b1) n_presc = n_presc + 1;
        if (frame_start_out === 1'b1) n_frame = n_frame + 1;
        if (drive_phase_out !== ph_q) n_tog = n_tog + 1;
        ph_q = drive_phase_out;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the read edge
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd

    // gap after each pulse lets the prescaler output land before checks
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk_in);
            src_tick_in <= 1'b1;
            @(posedge core_clk_in);
            src_tick_in <= 1'b0;
            repeat (2) @(posedge core_clk_in);
        end
    endtask : tick

    // stop, configure, start, then let the active flag settle
    task automatic start(input logic [7:0] ps);
        wr(`LCDPP_ADDR_CTRL, 8'h01);
        wr(`LCDPP_ADDR_PHASE, ps);
        wr(`LCDPP_ADDR_CTRL, 8'h81);
        repeat (3) @(posedge core_clk_in);
        base_p = n_presc;
        base_f = n_frame;
        base_t = n_tog;
    endtask : start

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        reset_n_in   = 1'b0;
        reg_addr_in  = 9'h000;
        reg_wdata_in = 8'h00;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        src_tick_in  = 1'b0;
        repeat (8) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        // configuration rows: readback, ignored status bits, bias per mux
        foreach (rows[i])
        begin
            wr(`LCDPP_ADDR_CTRL, rows[i].ctrl);
            wr(`LCDPP_ADDR_PHASE, rows[i].ps);
            rd(`LCDPP_ADDR_PHASE, rdv);
            chk("phase_reg", rows[i].exp_ps, rdv);
            rd(`LCDPP_ADDR_CTRL, rdv);
            chk("ctrl_reg", rows[i].ctrl & 8'h83, rdv);
            chk("bias", {6'h00, bias_mode_out}, {6'h00, rows[i].exp_bias});
        end
        // unmapped address: write ignored, read zero
        wr(9'h109, 8'hFF);
        rd(9'h109, rdv);
        chk("unmapped", 8'h00, rdv);
        rd(`LCDPP_ADDR_PHASE, rdv);
        chk("phase_after_unmapped", 8'h10, rdv);
        // divide ratio at both ends and in between
        foreach (ratios[k])
        begin
            start(8'(ratios[k]));
            rd(`LCDPP_ADDR_PHASE, rdv);
            chk("active_on", 8'h30 | 8'(ratios[k]), rdv);
            for (int i = 1; i <= (ratios[k] + 1) * 3; i++)
            begin
                tick(1);
                chk("presc_count", 8'(i / (ratios[k] + 1)), 8'(n_presc - base_p));
            end
        end
        // disabling mid-count restarts the prescaler
        start(8'h03);
        tick(2);
        start(8'h03);
        tick(3);
        chk("restart_none", 8'h00, 8'(n_presc - base_p));
        tick(1);
        chk("restart_one", 8'h01, 8'(n_presc - base_p));
        // type A: two ticks per common, phase flips on every tick
        start(8'h00);
        tick(8);
        chk("a_toggles", 8'h08, 8'(n_tog - base_t));
        chk("a_frames", 8'h02, 8'(n_frame - base_f));
        chk("a_com", 8'h00, {6'h00, com_index_out});
        // type B: one tick per common, phase flips once per frame
        start(8'h80);
        tick(8);
        chk("b_toggles", 8'h04, 8'(n_tog - base_t));
        chk("b_frames", 8'h04, 8'(n_frame - base_f));
        rd(`LCDPP_ADDR_PHASE, rdv);
        chk("permit_first_com", 8'hB0, rdv);
        tick(1);
        chk("b_com_last", 8'h01, {6'h00, com_index_out});
        rd(`LCDPP_ADDR_PHASE, rdv);
        chk("permit_last_com", 8'hA0, rdv);
        // stop: active flag drops, com and phase held at zero, ticks refused
        wr(`LCDPP_ADDR_CTRL, 8'h01);
        repeat (2) @(posedge core_clk_in);
        rd(`LCDPP_ADDR_PHASE, rdv);
        chk("active_off", 8'h90, rdv);
        base_p = n_presc;
        tick(4);
        chk("off_ticks", 8'h00, 8'(n_presc - base_p));
        chk("off_com_phase", 8'h00, {5'h00, com_index_out, drive_phase_out});
        // second reset returns both registers to their reset values
        @(posedge core_clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd(`LCDPP_ADDR_PHASE, rdv);
        chk("rst_phase", 8'h10, rdv);
        rd(`LCDPP_ADDR_CTRL, rdv);
        chk("rst_ctrl", 8'h03, rdv);
        tally_and_finish();
    end
endmodule : lcdpp_top_tb_top
